// *** hw/scbc_pkg.sv ***
// Summary of operation
// RQ1: Data write queues low byte for sending
// RQ2: Data read pops oldest byte, upper zero
// RQ3: Ninth received bit shown at bit 7
// RQ4: Bit 6 picks odd or even parity
// RQ5: Bit 5 enables parity generate and check
// RQ6: Software: parity only in 7/8-bit formats
// RQ7: Bit 4 flags receive overrun
// RQ8: Bit 3 flags parity error or underrun
// RQ9: Bit 2 flags framing error
// RQ10: Bit 1 picks rising or falling clock edge
// RQ11: Software: edge bit zero when clock drives out
// RQ12: Bit 0 low: shift clock from generator
// RQ13: Bit 0 high: shift clock from pin
// RQ14: Registers reset zero, unused bits read zero
package scbc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_WIDTH = 9;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned LVL_W = 5;
    // Register byte offsets
    localparam logic [7:0] ADDR_BUF = 8'h04;
    localparam logic [7:0] ADDR_CR = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    // Control/status bit positions
    localparam int unsigned CR_NINTH = 7;
    localparam int unsigned CR_EVEN = 6;
    localparam int unsigned CR_PE = 5;
    localparam int unsigned CR_OVERRUN_FLAG = 4;
    localparam int unsigned CR_PARITY_UNDERRUN_FLAG = 3;
    localparam int unsigned CR_FRAMING_ERROR_FLAG = 2;
    localparam int unsigned CR_SHIFT_CLOCK_EDGE_SELECT = 1;
    localparam int unsigned CR_IOC = 0;
    localparam logic [7:0] CR_WMASK = 8'h63;
    localparam logic [7:0] CR_RESET = 8'h00;
    // Channel configuration fields
    localparam int unsigned CFG_FMT_LSB = 0;
    localparam int unsigned CFG_RXEN = 2;
    localparam int unsigned CFG_TXEN = 3;
    localparam int unsigned CFG_TX9 = 4;
    localparam int unsigned CFG_DIV_LSB = 16;
    localparam logic [31:0] CFG_MASK = 32'hFFFF_001F;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // Status fields
    localparam int unsigned STAT_TX_LVL_LSB = 0;
    localparam int unsigned STAT_RX_LVL_LSB = 8;
    localparam int unsigned STAT_TX_BUSY = 16;
    localparam int unsigned STAT_RX_BUSY = 17;
    // Oversampling and bus response codes
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {FMT_IO, FMT_UART7, FMT_UART8, FMT_UART9} scbc_fmt_type;
    typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_IO} scbc_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} scbc_rx_state_type;
endpackage

// *** hw/scbc_fifo_if.sv ***
`timescale 1ns/1ns
interface scbc_fifo_if #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
);
    localparam int LW = $clog2(DEPTH + 1);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [LW-1:0] level;
    modport store(input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
    modport user(output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
endinterface

// *** hw/scbc_fifo.sv ***
`timescale 1ns/1ns
module scbc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Queue ports
    scbc_fifo_if.store port
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [LW-1:0] count;
    } scbc_fifo_state_type;
    scbc_fifo_state_type q, d;
    logic push;
    logic pop;

    assign port.in_ready = q.count != LW'(DEPTH);
    assign port.out_valid = q.count != '0;
    assign port.out_data = q.mem[q.rd];
    assign port.level = q.count;
    assign push = port.in_valid && port.in_ready;
    assign pop = port.out_ready && port.out_valid;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = port.in_data;
            d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + PW'(1);
        end
        if (pop) begin
            d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + PW'(1);
        end
        if (push && !pop) begin
            d.count = q.count + LW'(1);
        end else if (pop && !push) begin
            d.count = q.count - LW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** hw/scbc_baud.sv ***
`timescale 1ns/1ns
module scbc_baud
    import scbc_pkg::*;
#(
    parameter int W = DIV_W
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Divider control
    input wire logic [W-1:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } scbc_baud_state_type;
    scbc_baud_state_type q, d;

    assign tick = q.tick;

    // One pulse every divisor+1 cycles
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.count >= divisor) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** hw/scbc_channel.sv ***
`timescale 1ns/1ns
module scbc_channel
    import scbc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line
    output logic txd,
    input wire logic rxd,
    // Shift clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe
);
    typedef struct packed {
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] cr;
        logic [31:0] cfg;
        scbc_tx_state_type tx_state;
        logic [11:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_os;
        scbc_rx_state_type rx_state;
        logic [9:0] rx_shift;
        logic [3:0] rx_bits;
        logic [3:0] rx_os;
        logic txd;
        logic sclk_out;
        logic sclk_oe;
        logic sclk_prev;
    } scbc_state_type;

    scbc_state_type q, d;
    logic tick;

    scbc_fifo_if #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tx_if ();
    scbc_fifo_if #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_if ();

    scbc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(tx_if.store)
    );

    scbc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(rx_if.store)
    );

    scbc_baud #(.W(DIV_W)) u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .divisor(q.cfg[CFG_DIV_LSB +: DIV_W]),
        .tick(tick)
    );

    // Builds an asynchronous frame, start bit first, stop bits fill the top
    function automatic logic [11:0] scbc_frame(input logic [7:0] data, input logic seven,
                                               input logic ext_en, input logic ext_bit);
        logic [11:0] f;
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || !seven) begin
                f[i + 1] = data[i];
            end
        end
        if (ext_en) begin
            f[seven ? 8 : 9] = ext_bit;
        end
        return f;
    endfunction

    // Parity bit for the selected polarity
    function automatic logic scbc_parity(input logic [7:0] data, input logic seven,
                                         input logic even);
        return ^(data & (seven ? 8'h7F : 8'hFF)) ^ ~even;
    endfunction

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign txd = q.txd;
    assign sclk_out = q.sclk_out;
    assign sclk_oe = q.sclk_oe;

    always_comb begin
        scbc_fmt_type fmt;
        logic io_mode;
        logic seven;
        logic ext_en;
        logic txen;
        logic rxen;
        logic wr_done;
        logic rise;
        logic fall;
        logic act_edge;
        logic sh_edge;
        logic [3:0] n_frame;
        logic [3:0] n_rx;
        logic [9:0] al;
        logic [7:0] rx_byte;
        logic ext_rx;
        d = q;
        tx_if.in_valid = 1'b0;
        tx_if.in_data = '0;
        tx_if.out_ready = 1'b0;
        rx_if.in_valid = 1'b0;
        rx_if.in_data = '0;
        rx_if.out_ready = 1'b0;
        fmt = scbc_fmt_type'(q.cfg[CFG_FMT_LSB +: 2]);
        io_mode = fmt == FMT_IO;
        seven = fmt == FMT_UART7;
        ext_en = q.cr[CR_PE] || fmt == FMT_UART9;
        txen = q.cfg[CFG_TXEN];
        rxen = q.cfg[CFG_RXEN];
        wr_done = 1'b0;
        n_frame = (seven ? 4'h9 : 4'hA) + {3'h0, ext_en};
        n_rx = n_frame - 4'h1;
        rise = sclk_in && !q.sclk_prev;
        fall = !sclk_in && q.sclk_prev;
        act_edge = q.cr[CR_SHIFT_CLOCK_EDGE_SELECT] ? fall : rise; // [RQ10]
        sh_edge = q.cr[CR_SHIFT_CLOCK_EDGE_SELECT] ? rise : fall; // [RQ10]
        al = '0;
        rx_byte = '0;
        ext_rx = 1'b0;
        d.sclk_prev = sclk_in;

        // Write channel
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.bresp = RESP_OKAY;
            if (q.aw_addr == ADDR_BUF) begin
                // Full queue holds the write off
                if (!q.w_strb[0] || tx_if.in_ready) begin
                    tx_if.in_valid = q.w_strb[0]; // [RQ1]
                    tx_if.in_data = {q.cfg[CFG_TX9], q.w_data[7:0]}; // [RQ1]
                    wr_done = 1'b1;
                end
            end else if (q.aw_addr == ADDR_CR) begin
                if (q.w_strb[0]) begin
                    d.cr = (q.cr & ~CR_WMASK) | (q.w_data[7:0] & CR_WMASK); // [RQ14]
                end
                wr_done = 1'b1;
            end else if (q.aw_addr == ADDR_CFG) begin
                for (int b = 0; b < 4; b++) begin
                    if (q.w_strb[b]) begin
                        d.cfg[8*b +: 8] = q.w_data[8*b +: 8];
                    end
                end
                d.cfg = d.cfg & CFG_MASK;
                wr_done = 1'b1;
            end else if (q.aw_addr == ADDR_STAT) begin
                wr_done = 1'b1;
            end else begin
                d.bresp = RESP_SLVERR;
                wr_done = 1'b1;
            end
        end
        if (wr_done) begin
            d.bvalid = 1'b1;
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
        end
        d.awready = !d.aw_have;
        d.wready = !d.w_have;

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (s_axi_araddr == ADDR_BUF) begin
                d.rdata[7:0] = rx_if.out_valid ? rx_if.out_data[7:0] : 8'h00; // [RQ2]
                rx_if.out_ready = 1'b1; // [RQ2]
            end else if (s_axi_araddr == ADDR_CR) begin
                d.rdata[7:0] = q.cr; // [RQ14]
                // Reading reports the error flags and clears them
                d.cr[CR_OVERRUN_FLAG] = 1'b0;
                d.cr[CR_PARITY_UNDERRUN_FLAG] = 1'b0;
                d.cr[CR_FRAMING_ERROR_FLAG] = 1'b0;
            end else if (s_axi_araddr == ADDR_CFG) begin
                d.rdata = q.cfg;
            end else if (s_axi_araddr == ADDR_STAT) begin
                d.rdata[STAT_TX_LVL_LSB +: LVL_W] = tx_if.level;
                d.rdata[STAT_RX_LVL_LSB +: LVL_W] = rx_if.level;
                d.rdata[STAT_TX_BUSY] = q.tx_state != TX_IDLE;
                d.rdata[STAT_RX_BUSY] = q.rx_state != RX_IDLE;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;

        // Clock output drive in generator-clocked I/O mode
        d.sclk_oe = io_mode && !q.cr[CR_IOC]; // [RQ12]

        // Transmit and I/O shift engine
        case (q.tx_state)
            TX_IDLE: begin
                d.txd = 1'b1;
                d.sclk_out = 1'b1;
                d.tx_bits = '0;
                if (io_mode && q.cr[CR_IOC] && act_edge) begin
                    // External clock started a byte with nothing loaded
                    d.rx_shift = {rxd, q.rx_shift[9:1]}; // [RQ13]
                    d.tx_bits = 4'h1;
                    d.tx_shift = 12'hFFF;
                    d.tx_state = TX_IO;
                    if (txen) begin
                        d.cr[CR_PARITY_UNDERRUN_FLAG] = 1'b1; // [RQ8]
                    end
                end else if (txen && tx_if.out_valid) begin
                    tx_if.out_ready = 1'b1;
                    d.tx_os = '0;
                    if (!io_mode) begin
                        d.tx_shift = scbc_frame(tx_if.out_data[7:0], seven, ext_en,
                            q.cr[CR_PE] ? scbc_parity(tx_if.out_data[7:0], seven,
                            q.cr[CR_EVEN]) : tx_if.out_data[8]); // [RQ4] [RQ5]
                        d.tx_bits = n_frame;
                        d.tx_state = TX_UART;
                    end else begin
                        d.tx_shift = {4'hF, tx_if.out_data[7:0]};
                        d.tx_state = TX_IO;
                    end
                    d.txd = d.tx_shift[0];
                end
            end
            TX_UART: begin
                if (tick) begin
                    d.tx_os = q.tx_os + 4'h1;
                    if (q.tx_os == OS_LAST) begin
                        d.tx_os = '0;
                        d.tx_shift = {1'b1, q.tx_shift[11:1]};
                        d.tx_bits = q.tx_bits - 4'h1;
                        d.txd = d.tx_shift[0];
                        if (q.tx_bits == 4'h1) begin
                            d.txd = 1'b1;
                            d.tx_state = TX_IDLE;
                        end
                    end
                end
            end
            TX_IO: begin
                if (!q.cr[CR_IOC]) begin
                    // Generator clock: fall shifts out, rise samples
                    act_edge = tick && !q.sclk_out; // [RQ12]
                    sh_edge = tick && q.sclk_out; // [RQ12]
                    if (tick) begin
                        d.sclk_out = !q.sclk_out;
                    end
                end
                if (sh_edge && q.tx_bits != 4'h0) begin
                    d.tx_shift = {1'b1, q.tx_shift[11:1]}; // [RQ13]
                    d.txd = d.tx_shift[0];
                end
                if (act_edge) begin
                    d.rx_shift = {rxd, q.rx_shift[9:1]}; // [RQ13]
                    d.tx_bits = q.tx_bits + 4'h1;
                    if (q.tx_bits == 4'h7) begin
                        d.tx_state = TX_IDLE;
                        d.sclk_out = 1'b1;
                        if (rxen) begin
                            if (rx_if.in_ready) begin
                                rx_if.in_valid = 1'b1;
                                rx_if.in_data = {1'b0, d.rx_shift[9:2]};
                            end else begin
                                d.cr[CR_OVERRUN_FLAG] = 1'b1; // [RQ7]
                            end
                        end
                    end
                end
                if (!io_mode) begin
                    d.tx_state = TX_IDLE;
                end
            end
            default: d.tx_state = TX_IDLE;
        endcase

        // Asynchronous receiver, 16x oversampled
        case (q.rx_state)
            RX_IDLE: begin
                if (!io_mode && rxen && !rxd) begin
                    d.rx_os = '0;
                    d.rx_state = RX_START;
                end
            end
            RX_START: begin
                if (tick) begin
                    d.rx_os = q.rx_os + 4'h1;
                    if (q.rx_os == OS_MID) begin
                        d.rx_os = '0;
                        d.rx_bits = '0;
                        d.rx_state = rxd ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    d.rx_os = q.rx_os + 4'h1;
                    if (q.rx_os == OS_LAST) begin
                        d.rx_os = '0;
                        d.rx_shift = {rxd, q.rx_shift[9:1]};
                        d.rx_bits = q.rx_bits + 4'h1;
                        if (d.rx_bits == n_rx) begin
                            d.rx_state = RX_IDLE;
                            al = d.rx_shift >> (4'hA - n_rx);
                            rx_byte = al[7:0] & (seven ? 8'h7F : 8'hFF);
                            ext_rx = seven ? al[7] : al[8];
                            if (!al[n_rx - 4'h1]) begin
                                d.cr[CR_FRAMING_ERROR_FLAG] = 1'b1; // [RQ9]
                            end
                            if (q.cr[CR_PE]
                                && ext_rx != scbc_parity(rx_byte, seven, q.cr[CR_EVEN])) begin
                                d.cr[CR_PARITY_UNDERRUN_FLAG] = 1'b1; // [RQ4] [RQ5] [RQ8]
                            end
                            if (fmt == FMT_UART9) begin
                                d.cr[CR_NINTH] = ext_rx; // [RQ3]
                            end
                            if (rx_if.in_ready) begin
                                rx_if.in_valid = 1'b1;
                                rx_if.in_data = {fmt == FMT_UART9 && ext_rx, rx_byte};
                            end else begin
                                d.cr[CR_OVERRUN_FLAG] = 1'b1; // [RQ7]
                            end
                        end
                    end
                end
                if (io_mode || !rxen) begin
                    d.rx_state = RX_IDLE;
                end
            end
            default: d.rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0; // [RQ14]
            q.cr <= CR_RESET;
            q.cfg <= CFG_RESET;
            q.txd <= 1'b1;
            q.sclk_out <= 1'b1;
            q.sclk_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

// *** bench/scbc_properties.sv ***
`timescale 1ns/1ns
module scbc_properties
    import scbc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic txd,
    input wire logic sclk_oe
);
    logic [ADDR_W-1:0] ra_q;
    logic mapped;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // Address of the read in flight
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra_q <= s_axi_araddr;
        end
    end
    assign mapped = ra_q inside {ADDR_BUF, ADDR_CR, ADDR_CFG, ADDR_STAT};
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_held: assert property (s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_write_after_both: assert property (
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("response before address and data");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_read_upper: assert property (
        s_axi_rvalid && (ra_q == ADDR_BUF || ra_q == ADDR_CR)
        |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_resp_code: assert property (
        s_axi_rvalid |-> s_axi_rresp == (mapped ? RESP_OKAY : RESP_SLVERR))
        else $error("wrong read response code");
    a_reset_idle: assert property (
        disable iff (1'b0) !aresetn |=> txd && !sclk_oe && !s_axi_bvalid)
        else $error("outputs not idle after reset");
endmodule
bind scbc_channel scbc_properties u_props (.*);

// *** bench/scbc_serial_peer.sv ***
`timescale 1ns/1ns
module scbc_serial_peer (
    // Clock and bench controls
    input wire logic aclk,
    input wire logic hold_low,
    input wire logic ext_run,
    // Serial pins
    input wire logic txd,
    output logic rxd,
    output logic sclk_in
);
    logic [1:0] div_q = 2'h0;
    logic sclk_q = 1'b1;
    // Echo the line; hold_low spoils a frame on purpose
    assign rxd = txd & ~hold_low;
    assign sclk_in = sclk_q;
    // Outside clock runs only while asked, idles high
    always @(posedge aclk) begin
        if (ext_run) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) sclk_q <= ~sclk_q;
        end
    end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench
    import scbc_pkg::*;
;
    localparam int FR = 200;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic txd, rxd, sclk_in, sclk_out, sclk_oe, hold_low, ext_run;
    int fails, n_compared, sclk_falls;
    logic [7:0] cfg_tab [4] = '{8'h0E, 8'h0D, 8'h1F, 8'h0F};
    logic [7:0] cr_tab [4] = '{8'h20, 8'h60, 8'h00, 8'h00};
    scbc_channel DUT (.*);
    scbc_serial_peer peer (.*);
    // Driven shift clock falls, one per bit sent
    always @(negedge sclk_out) sclk_falls++;
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk($sformatf("read %h", a), e, s_axi_rdata);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        fails = 0;
        n_compared = 0;
        aresetn <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0000_0000_0000;
        s_axi_wstrb <= 4'hF;
        {hold_low, ext_run} <= 2'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_BUF, 32'h0000_0000);
        rd(ADDR_CR, 32'h0000_0000);
        wr(ADDR_CR, 32'hFFFF_FFFF);
        rd(ADDR_CR, 32'h0000_0063);
        wr(8'h20, 32'h0000_00FF);
        rd(8'h20, 32'h0000_0000);
        wr(ADDR_CR, 32'h0000_0000);
        wr(ADDR_CFG, 32'h0000_000E);
        // Fill past the queue so writes stall and two received bytes are dropped
        for (int i = 0; i < 18; i++) begin
            wr(ADDR_BUF, 32'(i));
        end
        repeat (18 * 170) @(posedge aclk);
        rd(ADDR_CR, 32'h0000_0010);
        rd(ADDR_STAT, 32'h0000_1000);
        for (int i = 0; i < 16; i++) begin
            rd(ADDR_BUF, 32'(i));
        end
        rd(ADDR_BUF, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CFG, {24'h00_0000, cfg_tab[i]});
            wr(ADDR_CR, {24'h00_0000, cr_tab[i]});
            wr(ADDR_BUF, 32'h0000_015A);
            repeat (FR) @(posedge aclk);
            rd(ADDR_BUF, 32'h0000_005A);
            rd(ADDR_CR, {24'h00_0000, cr_tab[i] | (i == 2 ? 8'h80 : 8'h00)});
        end
        wr(ADDR_CFG, 32'h0000_000E);
        wr(ADDR_CR, 32'h0000_0000);
        hold_low <= 1'b1;
        wr(ADDR_BUF, 32'h0000_0000);
        repeat (156) @(posedge aclk);
        hold_low <= 1'b0;
        rd(ADDR_CR, 32'h0000_0004);
        rd(ADDR_BUF, 32'h0000_0000);
        wr(ADDR_CFG, 32'h0000_000C);
        wr(ADDR_BUF, 32'h0000_00C3);
        repeat (40) @(posedge aclk);
        chk("sclk_oe", 32'h0000_0001, 32'(sclk_oe));
        chk("sclk_out falls", 32'h0000_0008, 32'(sclk_falls));
        rd(ADDR_BUF, 32'h0000_00C3);
        // Outside clock with nothing loaded gives an underrun
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CR, 32'(2 * i + 1));
            ext_run <= 1'b1;
            repeat (64) @(posedge aclk);
            ext_run <= 1'b0;
            rd(ADDR_CR, 32'(2 * i + 9));
        end
        tally_and_finish();
    end
endmodule
